// [sim/rtn_link_props.sv]
// Port-level checks of the radio link node, bound into rtn_link.
// Assumes ce_in stays high and configuration holds steady between resets.
`timescale 1ns/1ps
`include "rtn_map.svh"

module rtn_link_props #(
  parameter int unsigned CYC_PER_US = 100
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [3:0] cfg_node_in,
  input wire logic [4:0] cfg_nodes_in,
  input wire logic [4:0] cfg_chan_in,
  input wire logic [255:0] cfg_serials_in,
  input wire logic rx_valid_in,
  input wire logic [63:0] rx_word_in,
  input wire logic tx_valid_out,
  input wire logic [63:0] tx_word_out,
  input wire logic tx_ready_in,
  input wire logic [4:0] rf_chan_out,
  input wire logic [11:0] rf_freq_mhz_out,
  input wire logic joined_out,
  input wire logic frame_tick_out,
  input wire logic [255:0] mem_data_out,
  input wire logic [15:0] mem_ok_out
);
  import rtn_pkg::*;
  localparam int FT [0:14] = '{`RTN_FT2_US, `RTN_FT3_US, `RTN_FT4_US, `RTN_FT5_US,
    `RTN_FT6_US, `RTN_FT7_US, `RTN_FT8_US, `RTN_FT9_US, `RTN_FT10_US, `RTN_FT11_US,
    `RTN_FT12_US, `RTN_FT13_US, `RTN_FT14_US, `RTN_FT15_US, `RTN_FT16_US};

  function automatic logic [15:0] crc16(input logic [47:0] d);
    logic [15:0] c;
    c = `RTN_CRC_INIT;
    for (int i = 47; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `RTN_CRC_POLY : 16'h0000);
    return c;
  endfunction : crc16

  logic [255:0] okx_w;
  int unsigned nidx_w;
  int unsigned cnt_r;
  logic seen_r;
  logic good_w;
  for (genvar k = 0; k < 16; k++)
  begin : g_ok
    assign okx_w[16*k +: 16] = {16{mem_ok_out[k]}};
  end
  assign nidx_w = (cfg_nodes_in < 5'd2) ? 0 : (cfg_nodes_in > 5'd16) ? 14 : cfg_nodes_in - 2;
  assign good_w = rx_word_in[15:0] == crc16(rx_word_in[63:16])
    && rx_word_in[63:48] == cfg_serials_in[16*rx_word_in[47:44] +: 16]
    && {1'b0, rx_word_in[47:44]} < cfg_nodes_in && rx_word_in[47:44] != cfg_node_in;

  // Interval count is trusted only from a tick seen while joined
  always_ff @(posedge mclk_in)
  begin
    cnt_r <= (!rstn_in || frame_tick_out) ? 0 : cnt_r + 1;
    seen_r <= rstn_in && joined_out && (frame_tick_out || seen_r);
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence join_req_s;
    rx_valid_in && !joined_out && cfg_node_in != 4'h0 && rx_word_in[43:40] == 4'h0 && good_w;
  endsequence
  sequence leader_up_s;
    $rose(rstn_in) && cfg_node_in == 4'h0;
  endsequence

  chk_chan_map: assert property (joined_out |-> rf_chan_out == cfg_chan_in + 5'd10)
    else $error("rf channel is not local plus ten");
  chk_freq_map: assert property (rf_freq_mhz_out == 12'd2350 + 12'd5 * {7'h0, rf_chan_out})
    else $error("frequency does not follow channel");
  chk_tx_serial: assert property (tx_valid_out |-> tx_word_out[63:44] ==
    {cfg_serials_in[16*cfg_node_in +: 16], cfg_node_in}) else $error("own serial wrong");
  chk_tx_crc: assert property (tx_valid_out |-> tx_word_out[15:0] == crc16(tx_word_out[63:16]))
    else $error("sent checksum wrong");
  chk_safe_zero: assert property ((mem_data_out & ~okx_w) == 256'h0)
    else $error("data shown for a dead origin");
  chk_frame_len: assert property (frame_tick_out && seen_r |->
    cnt_r == FT[nidx_w] * CYC_PER_US - 1) else $error("frame length off");
  chk_leader_go: assert property (leader_up_s |-> ##[0:3] joined_out)
    else $error("leader did not start");
  chk_join_word: assert property (join_req_s |-> ##2 joined_out)
    else $error("no join on leader word");
  chk_leave_clear: assert property ($fell(joined_out) |-> ##[0:2] mem_ok_out == 16'h0)
    else $error("memories kept after leaving");
  chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_word_out))
    else $error("stalled word dropped");
endmodule : rtn_link_props

bind rtn_link rtn_link_props #(.CYC_PER_US(CYC_PER_US)) u_props (.mclk_in(mclk_in),
  .rstn_in(rstn_in), .cfg_node_in(cfg_node_in), .cfg_nodes_in(cfg_nodes_in),
  .cfg_chan_in(cfg_chan_in), .cfg_serials_in(cfg_serials_in), .rx_valid_in(rx_valid_in),
  .rx_word_in(rx_word_in), .tx_valid_out(tx_valid_out), .tx_word_out(tx_word_out),
  .tx_ready_in(tx_ready_in), .rf_chan_out(rf_chan_out), .rf_freq_mhz_out(rf_freq_mhz_out),
  .joined_out(joined_out), .frame_tick_out(frame_tick_out), .mem_data_out(mem_data_out),
  .mem_ok_out(mem_ok_out));

// [sim/rtn_peer.sv]
// Far-side radio model: sends checksummed air words and takes sent ones.
// Assumes the testbench calls send and drives stall_r on mclk_in edges.
`timescale 1ns/1ps
`include "rtn_map.svh"

module rtn_peer (
  input wire logic mclk_in,
  input wire logic tx_valid_in,
  input wire logic [63:0] tx_word_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [63:0] rx_word_out
);
  import rtn_pkg::*;
  logic stall_r = 1'b0;
  logic [63:0] got_q [$];
  initial
  begin
    rx_valid_out = 1'b0;
    rx_word_out = 64'h0;
  end
  assign tx_ready_out = !stall_r;
  always @(posedge mclk_in)
    if (tx_valid_in && tx_ready_out)
      got_q.push_back(tx_word_in);

  function automatic logic [15:0] crc16(input logic [47:0] d);
    logic [15:0] c;
    c = `RTN_CRC_INIT;
    for (int i = 47; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `RTN_CRC_POLY : 16'h0000);
    return c;
  endfunction : crc16

  task automatic send(input logic [15:0] ser, input logic [3:0] snd, input logic [3:0] org,
    input logic [15:0] dat, input logic bad);
    logic [63:0] w;
    w = {ser, snd, org, 8'h00, dat, 16'h0000};
    w[15:0] = crc16(w[63:16]) ^ {15'h0, bad};
    @(posedge mclk_in);
    rx_valid_out <= 1'b1;
    rx_word_out <= w;
    @(posedge mclk_in);
    rx_valid_out <= 1'b0;
    // Stale word is inverted so nothing can lean on it
    rx_word_out <= ~w;
  endtask : send
endmodule : rtn_peer

// [sim/testbench.sv]
// Self-checking bench of one radio link node against the far-side model.
// Assumes frame times scaled by CYC_PER_US of 1; ce_in tied high.
`timescale 1ns/1ps

module testbench;
  import rtn_pkg::*;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] cfg_node = 4'h0;
  logic [4:0] cfg_nodes = 5'd2;
  logic [4:0] cfg_chan = 5'd1;
  logic [255:0] serials = 256'h0;
  logic [15:0] local_data = 16'hc3a5;
  logic rx_valid, tx_valid_out, tx_ready, joined_out, frame_tick_out;
  logic [63:0] rx_word, tx_word_out;
  logic [4:0] rf_chan_out;
  logic [11:0] rf_freq_mhz_out;
  logic [255:0] mem_data_out;
  logic [15:0] mem_ok_out;
  int n_errors = 0;
  int cmp_count = 0;

  always #5 mclk_in = ~mclk_in;

  rtn_link #(.CYC_PER_US(1)) dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(1'b1),
    .cfg_node_in(cfg_node), .cfg_nodes_in(cfg_nodes), .cfg_chan_in(cfg_chan),
    .cfg_serials_in(serials), .cfg_tmo_long_in(8'h03), .cfg_tmo_short_in(8'h02),
    .cfg_tmo_sel_short_in(16'h0001), .local_data_in(local_data), .rx_valid_in(rx_valid),
    .rx_word_in(rx_word), .tx_valid_out(tx_valid_out), .tx_word_out(tx_word_out),
    .tx_ready_in(tx_ready), .rf_chan_out(rf_chan_out), .rf_freq_mhz_out(rf_freq_mhz_out),
    .joined_out(joined_out), .frame_tick_out(frame_tick_out), .mem_data_out(mem_data_out),
    .mem_ok_out(mem_ok_out));
  rtn_peer peer (.mclk_in(mclk_in), .tx_valid_in(tx_valid_out), .tx_word_in(tx_word_out),
    .tx_ready_out(tx_ready), .rx_valid_out(rx_valid), .rx_word_out(rx_word));

  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_tick(input int n, input int post);
    int i;
    for (int t = 0; t < n; t++)
    begin
      i = 0;
      do @(negedge mclk_in); while (frame_tick_out !== 1'b1 && ++i < 60000);
      if (i >= 60000)
      begin
        n_errors++;
        $display("BAD frame tick expected 1 seen 0");
        stop_test();
      end
    end
    repeat (post) @(negedge mclk_in);
  endtask : wait_tick

  task automatic do_reset(input logic [3:0] node, input logic [4:0] nodes, input logic [4:0] ch);
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    cfg_node <= node;
    cfg_nodes <= nodes;
    cfg_chan <= ch;
    repeat (20) @(posedge mclk_in);
    rstn_in <= 1'b1;
    peer.got_q.delete();
  endtask : do_reset

  task automatic t_leader;
    logic [63:0] w;
    w = {serials[15:0], 8'h00, 8'h00, local_data, 16'h0000};
    w[15:0] = peer.crc16(w[63:16]);
    do_reset(4'h0, 5'd2, 5'd16);
    peer.stall_r <= 1'b1;
    wait_tick(0, 40);
    chk("joined", 1, joined_out);
    chk("chan", 26, rf_chan_out);
    chk("freq", 2480, rf_freq_mhz_out);
    chk("stalled word", 1, tx_valid_out);
    @(posedge mclk_in);
    peer.stall_r <= 1'b0;
    wait_tick(0, 4);
    chk("own word", w, peer.got_q[0]);
  endtask : t_leader

  task automatic t_store;
    logic [63:0] w;
    w = 64'h0;
    peer.send(serials[31:16], 4'h1, 4'h1, 16'h5a5a, 1'b0);
    peer.send(serials[31:16], 4'h1, 4'h1, 16'hffff, 1'b1);
    peer.send(16'hbeef, 4'h1, 4'h1, 16'hffff, 1'b0);
    wait_tick(0, 4);
    chk("return hold", 0, mem_ok_out[1]);
    wait_tick(1, 3);
    chk("ok", 1, mem_ok_out[1]);
    chk("data", 16'h5a5a, mem_data_out[31:16]);
    wait_tick(1, 3);
    chk("ok aged", 1, mem_ok_out[1]);
    foreach (peer.got_q[i])
      if (peer.got_q[i][43:40] == 4'h1)
        w = peer.got_q[i];
    chk("repeat", 16'h5a5a, w[31:16]);
    chk("age bound", 1, w[39:32] < 8'h03);
    wait_tick(1, 3);
    chk("expired", 0, mem_ok_out[1]);
    chk("zeroed", 0, mem_data_out[31:16]);
    chk("leader runs", 1, joined_out);
  endtask : t_store

  task automatic t_follow;
    do_reset(4'h2, 5'd3, 5'd5);
    wait_tick(0, 5);
    chk("scan chan", 11, rf_chan_out);
    peer.send(16'hbeef, 4'h1, 4'h0, 16'h0001, 1'b0);
    wait_tick(0, 4);
    chk("no join", 0, joined_out);
    peer.send(serials[31:16], 4'h1, 4'h0, 16'h0001, 1'b0);
    wait_tick(0, 4);
    chk("joined", 1, joined_out);
    chk("chan", 15, rf_chan_out);
    chk("freq", 2425, rf_freq_mhz_out);
    wait_tick(2, 5);
    chk("left", 0, joined_out);
    chk("cleared", 0, mem_ok_out);
  endtask : t_follow

  initial
  begin
    for (int k = 0; k < 16; k++)
      serials[16*k +: 16] = 16'h3c00 + k;
    t_leader();
    t_store();
    t_follow();
    stop_test();
  end
endmodule : testbench

// [src/rtn_buf.sv]
// Two-entry buffer between the slot sequencer and the radio transmitter.
// Assumes both sides share mclk_in; all outputs come from flip-flops.
`timescale 1ns/1ps

module rtn_buf (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  input wire logic [63:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [63:0] out_data_out,
  input wire logic out_ready_in
);
  logic v0_r;
  logic v1_r;
  logic [63:0] d0_r;
  logic [63:0] d1_r;
  wire push = in_valid_in && !v1_r;
  wire pop = v0_r && out_ready_in;
  wire v0_nxt = v1_r || (v0_r && !pop) || push;
  wire v1_nxt = (v1_r && !pop) || (push && v0_r && !pop);
  wire load0 = (!v0_r || pop);
  wire [63:0] d0_nxt = (load0 && v1_r) ? d1_r : ((load0 && push) ? in_data_in : d0_r);
  wire [63:0] d1_nxt = (push && v0_r && !(pop && !v1_r)) ? in_data_in : d1_r;

  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      d0_r <= 64'h0;
      d1_r <= 64'h0;
    end
    else if (ce_in)
    begin
      v0_r <= v0_nxt;
      v1_r <= v1_nxt;
      d0_r <= d0_nxt;
      d1_r <= d1_nxt;
    end
  end

  // Ready is a flop: a word is only refused while the spare entry is held
  assign in_ready_out = !v1_r;
  assign out_valid_out = v0_r;
  assign out_data_out = d0_r;
endmodule : rtn_buf

// [src/rtn_link.sv]
// Slot-ordered radio link node: channel, frame slots, filtering, repeat,
// ages and timeouts of the received memories.
// Assumes the radio front end delivers and takes 64-bit air words on
// mclk_in, and that configuration inputs are steady and on this clock.
//
// Functional notes
// - Local channel 1..16 tunes to plus 10
// - Channel 1 is 2405 MHz, 5 MHz steps
// - Talk only to listed serial numbers
// - Checksum every word, drop corrupted ones
// - Timed-out sender memories forced to zero
// - Slots run node 1 up to last
// - Frame time follows node count table
// - Latency one frame, never beyond timeout
// - Rebroadcast everything heard in own slot
// - Every sent item carries its age
// - Node 1 transmits right after start-up
// - Other nodes scan channels for node 1
// - Join on direct or repeated node 1
// - Node 1 lost: stop repeating, rescan
// - Other node lost: only its data stops
// - Loss and return force safe outputs
`timescale 1ns/1ps
`include "rtn_map.svh"

module rtn_link #(
  parameter int unsigned CYC_PER_US = `RTN_CLK_MHZ
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [3:0] cfg_node_in,
  input wire logic [4:0] cfg_nodes_in,
  input wire logic [4:0] cfg_chan_in,
  input wire logic [255:0] cfg_serials_in,
  input wire logic [7:0] cfg_tmo_long_in,
  input wire logic [7:0] cfg_tmo_short_in,
  input wire logic [15:0] cfg_tmo_sel_short_in,
  input wire logic [15:0] local_data_in,
  input wire logic rx_valid_in,
  input wire logic [63:0] rx_word_in,
  output logic tx_valid_out,
  output logic [63:0] tx_word_out,
  input wire logic tx_ready_in,
  output logic [4:0] rf_chan_out,
  output logic [11:0] rf_freq_mhz_out,
  output logic joined_out,
  output logic frame_tick_out,
  output logic [255:0] mem_data_out,
  output logic [15:0] mem_ok_out
);
  import rtn_pkg::*;

  function automatic logic [15:0] rtn_crc16(input logic [47:0] d);
    logic [15:0] c;
    c = `RTN_CRC_INIT;
    for (int i = 47; i >= 0; i--)
    begin
      if (c[15] ^ d[i])
        c = {c[14:0], 1'b0} ^ `RTN_CRC_POLY;
      else
        c = {c[14:0], 1'b0};
    end
    return c;
  endfunction : rtn_crc16

  function automatic logic [31:0] rtn_frame_us(input logic [4:0] n);
    case (n)
      5'd2: rtn_frame_us = 32'(`RTN_FT2_US);
      5'd3: rtn_frame_us = 32'(`RTN_FT3_US);
      5'd4: rtn_frame_us = 32'(`RTN_FT4_US);
      5'd5: rtn_frame_us = 32'(`RTN_FT5_US);
      5'd6: rtn_frame_us = 32'(`RTN_FT6_US);
      5'd7: rtn_frame_us = 32'(`RTN_FT7_US);
      5'd8: rtn_frame_us = 32'(`RTN_FT8_US);
      5'd9: rtn_frame_us = 32'(`RTN_FT9_US);
      5'd10: rtn_frame_us = 32'(`RTN_FT10_US);
      5'd11: rtn_frame_us = 32'(`RTN_FT11_US);
      5'd12: rtn_frame_us = 32'(`RTN_FT12_US);
      5'd13: rtn_frame_us = 32'(`RTN_FT13_US);
      5'd14: rtn_frame_us = 32'(`RTN_FT14_US);
      5'd15: rtn_frame_us = 32'(`RTN_FT15_US);
      default: rtn_frame_us = 32'(`RTN_FT16_US);
    endcase
  endfunction : rtn_frame_us

  rtn_state_t state_r;
  logic [4:0] chan_r;
  logic [31:0] scan_cnt_r;
  logic [31:0] slot_cnt_r;
  logic [3:0] slot_idx_r;
  logic frame_tick_r;
  logic [15:0] data_r [16];
  logic [7:0] age_r [16];
  logic have_r [16];
  logic hold_r [16];
  logic tx_busy_r;
  logic [3:0] tx_idx_r;

  // Frame and slot lengths; the slot divide is static while configured
  wire [4:0] nodes = (cfg_nodes_in < 5'd2) ? 5'd2
    : ((cfg_nodes_in > 5'd16) ? 5'd16 : cfg_nodes_in);
  wire [31:0] frame_cyc = rtn_frame_us(nodes) * CYC_PER_US;
  wire [31:0] slot_len = frame_cyc / 32'(nodes);
  wire [31:0] scan_cyc = 32'(`RTN_SCAN_DWELL_US) * CYC_PER_US;
  wire [3:0] last_idx = 4'(nodes - 5'd1);
  // Last slot takes the divide remainder so the frame keeps its full length
  wire [31:0] last_len = frame_cyc - slot_len * 32'(last_idx);
  wire is_leader = (cfg_node_in == 4'h0);
  wire running = (state_r == RTN_ST_RUN);
  wire [31:0] cur_len = (slot_idx_r == last_idx) ? last_len : slot_len;
  wire slot_end = running && (slot_cnt_r >= cur_len - 32'd1);
  wire frame_wrap = slot_end && (slot_idx_r == last_idx);

  // Received word fields
  wire [15:0] rx_ser = rx_word_in[63:`RTN_W_SER_LSB];
  wire [3:0] rx_snd = rx_word_in[`RTN_W_SND_LSB +: 4];
  wire [3:0] rx_org = rx_word_in[`RTN_W_ORG_LSB +: 4];
  wire [7:0] rx_age = rx_word_in[`RTN_W_AGE_LSB +: 8];
  wire [15:0] rx_dat = rx_word_in[`RTN_W_DAT_LSB +: 16];
  wire rx_crc_ok = (rtn_crc16(rx_word_in[63:16]) == rx_word_in[15:0]);
  wire rx_ser_ok = (rx_ser == cfg_serials_in[16 * rx_snd +: 16]);
  wire rx_ok = rx_valid_in && rx_crc_ok && rx_ser_ok
    && ({1'b0, rx_snd} < nodes) && ({1'b0, rx_org} < nodes)
    && (rx_snd != cfg_node_in) && (rx_org != cfg_node_in);
  wire join_ev = !running && !is_leader && rx_ok && (rx_org == 4'h0);

  // Expiry per origin, and loss of node 1 for a follower
  wire [15:0] expire;
  wire [15:0] take;
  logic [7:0] tmo [16];
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_tmo
      assign tmo[g] = cfg_tmo_sel_short_in[g] ? cfg_tmo_short_in : cfg_tmo_long_in;
      // Only a copy no older than the held one replaces it
      assign take[g] = (running || join_ev) && rx_ok && (rx_org == 4'(g))
        && (!have_r[g] || rx_age <= age_r[g]) && (rx_age < tmo[g]);
      assign expire[g] = frame_wrap && have_r[g] && !take[g]
        && (age_r[g] + 8'd1 >= tmo[g]);
    end
  endgenerate
  wire leader_lost = running && !is_leader && expire[0];
  wire drop_all = leader_lost || (state_r == RTN_ST_SCAN && !join_ev);

  // Protocol state
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      state_r <= RTN_ST_SCAN;
    else if (ce_in)
    begin
      case (state_r)
        RTN_ST_SCAN:
          if (is_leader || join_ev)
            state_r <= RTN_ST_RUN;
        RTN_ST_RUN:
          if (leader_lost)
            state_r <= RTN_ST_SCAN;
        default:
          state_r <= RTN_ST_SCAN;
      endcase
    end
  end

  // Channel: fixed while running, stepped 1..16 while scanning
  wire scan_step = !running && (scan_cnt_r >= scan_cyc - 32'd1);
  // The leader tunes on the same edge that it starts running
  wire [4:0] chan_nxt = (running || join_ev || is_leader) ? cfg_chan_in
    : (scan_step ? ((chan_r >= `RTN_CH_MAX) ? `RTN_CH_MIN : chan_r + 5'd1) : chan_r);
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      chan_r <= `RTN_CH_MIN;
      scan_cnt_r <= 32'd0;
    end
    else if (ce_in)
    begin
      chan_r <= chan_nxt;
      scan_cnt_r <= (running || scan_step) ? 32'd0 : scan_cnt_r + 32'd1;
    end
  end

  // Slot timer; a join aligns to the slot of the sender just heard
  wire [3:0] slot_idx_nxt = join_ev ? rx_snd
    : (slot_end ? ((slot_idx_r == last_idx) ? 4'h0 : slot_idx_r + 4'h1) : slot_idx_r);
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      slot_cnt_r <= 32'd0;
      slot_idx_r <= 4'h0;
      frame_tick_r <= 1'b0;
    end
    else if (ce_in)
    begin
      slot_cnt_r <= (!running || slot_end || join_ev) ? 32'd0 : slot_cnt_r + 32'd1;
      slot_idx_r <= running || join_ev ? slot_idx_nxt : 4'h0;
      frame_tick_r <= frame_wrap;
    end
  end

  // Received memories, one youngest copy per origin
  generate
    for (g = 0; g < 16; g++)
    begin : g_mem
      always_ff @(posedge mclk_in)
      begin
        if (!rstn_in)
        begin
          have_r[g] <= 1'b0;
          hold_r[g] <= 1'b1;
          age_r[g] <= 8'h0;
          data_r[g] <= 16'h0;
        end
        else if (ce_in)
        begin
          if (drop_all || expire[g])
          begin
            have_r[g] <= 1'b0;
            hold_r[g] <= 1'b1;
            data_r[g] <= 16'h0;
          end
          else if (take[g])
          begin
            have_r[g] <= 1'b1;
            age_r[g] <= rx_age;
            data_r[g] <= rx_dat;
          end
          else if (frame_wrap && have_r[g])
          begin
            age_r[g] <= age_r[g] + 8'd1;
            // A returning sender stays safe until the next frame wrap after its first copy
            hold_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Own slot: send the own item and each live item heard, in origin order
  wire own_slot_start = running && slot_cnt_r == 32'd0 && slot_idx_r == cfg_node_in
    && !tx_busy_r;
  wire buf_ready;
  wire tx_own = (tx_idx_r == cfg_node_in);
  wire tx_elig = tx_own || have_r[tx_idx_r];
  wire tx_push = tx_busy_r && buf_ready && tx_elig;
  wire tx_adv = tx_busy_r && (buf_ready || !tx_elig);
  wire [7:0] tx_age = tx_own ? 8'h0 : age_r[tx_idx_r];
  wire [15:0] tx_dat = tx_own ? local_data_in : data_r[tx_idx_r];
  wire [47:0] tx_body = {cfg_serials_in[16 * cfg_node_in +: 16], cfg_node_in, tx_idx_r,
    tx_age, tx_dat};
  wire [63:0] tx_word = {tx_body, rtn_crc16(tx_body)};

  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      tx_busy_r <= 1'b0;
      tx_idx_r <= 4'h0;
    end
    else if (ce_in)
    begin
      if (!running)
        tx_busy_r <= 1'b0;
      else if (own_slot_start)
      begin
        tx_busy_r <= 1'b1;
        tx_idx_r <= 4'h0;
      end
      else if (tx_adv)
      begin
        tx_busy_r <= (tx_idx_r != last_idx);
        tx_idx_r <= tx_idx_r + 4'h1;
      end
    end
  end

  // Back-pressure from the radio holds the sequencer, no word is lost
  rtn_buf u_buf (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .in_valid_in(tx_push),
    .in_data_in(tx_word),
    .in_ready_out(buf_ready),
    .out_valid_out(tx_valid_out),
    .out_data_out(tx_word_out),
    .out_ready_in(tx_ready_in)
  );

  // Registered user-facing outputs
  wire [4:0] chan_use = (chan_r < `RTN_CH_MIN || chan_r > `RTN_CH_MAX) ? `RTN_CH_MIN : chan_r;
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      rf_chan_out <= `RTN_CH_MIN + `RTN_CH_OFFSET;
      rf_freq_mhz_out <= `RTN_BASE_MHZ + `RTN_STEP_MHZ;
      joined_out <= 1'b0;
      frame_tick_out <= 1'b0;
      mem_ok_out <= 16'h0;
      mem_data_out <= 256'h0;
    end
    else if (ce_in)
    begin
      rf_chan_out <= chan_use + `RTN_CH_OFFSET;
      rf_freq_mhz_out <= `RTN_BASE_MHZ + `RTN_STEP_MHZ * {7'h0, chan_use};
      joined_out <= running;
      frame_tick_out <= frame_tick_r;
      for (int i = 0; i < 16; i++)
      begin
        mem_ok_out[i] <= have_r[i] && !hold_r[i];
        mem_data_out[16 * i +: 16] <= (have_r[i] && !hold_r[i]) ? data_r[i] : 16'h0;
      end
    end
  end
endmodule : rtn_link

// [src/rtn_map.svh]
// Constants of the slot-ordered radio link: channel mapping, frame times,
// word layout and checksum. Included by the link package and modules.
`ifndef RTN_MAP_SVH
`define RTN_MAP_SVH

// Channel mapping
`define RTN_CH_MIN 5'd1
`define RTN_CH_MAX 5'd16
`define RTN_CH_OFFSET 5'd10
`define RTN_BASE_MHZ 12'd2400
`define RTN_STEP_MHZ 12'd5

// Clock rate and scan dwell
`define RTN_CLK_MHZ 100
`define RTN_SCAN_DWELL_US 50000

// Frame time per node count, in microseconds
`define RTN_FT2_US 4250
`define RTN_FT3_US 6380
`define RTN_FT4_US 8500
`define RTN_FT5_US 11250
`define RTN_FT6_US 13880
`define RTN_FT7_US 16630
`define RTN_FT8_US 20000
`define RTN_FT9_US 23060
`define RTN_FT10_US 26250
`define RTN_FT11_US 29560
`define RTN_FT12_US 33750
`define RTN_FT13_US 37380
`define RTN_FT14_US 41130
`define RTN_FT15_US 45940
`define RTN_FT16_US 50000

// Air word: serial, sender, origin, age, data, checksum
`define RTN_W_SER_LSB 48
`define RTN_W_SND_LSB 44
`define RTN_W_ORG_LSB 40
`define RTN_W_AGE_LSB 32
`define RTN_W_DAT_LSB 16
`define RTN_CRC_POLY 16'h1021
`define RTN_CRC_INIT 16'hffff

`endif

// [src/rtn_pkg.sv]
// Types of the slot-ordered radio link.
// Assumes rtn_map.svh is on the include path.
`include "rtn_map.svh"

package rtn_pkg;
  typedef enum logic [1:0] {
    RTN_ST_SCAN = 2'b01,
    RTN_ST_RUN = 2'b10
  } rtn_state_t;
endpackage : rtn_pkg
